// >>> verilog/aftme_defines.svh
// Constants for the adaptive FIR tap memory engine and its host end
`ifndef AFTME_DEFINES_SVH
`define AFTME_DEFINES_SVH
// ==========================================
// Widths and sizes
`define AFTME_DW 16
`define AFTME_AW 12
`define AFTME_ACCW 40
`define AFTME_PRODW 32
`define AFTME_BUS_AW 14
`define AFTME_FRAC 15
`define AFTME_MEM_WORDS 4096
`define AFTME_FIFO_DEPTH 4
// ==========================================
// Bus spaces (bus address bits 13:12)
`define AFTME_SPACE_X 2'h0
`define AFTME_SPACE_Y 2'h1
`define AFTME_SPACE_REG 2'h2
// ==========================================
// Register offsets (bus address bits 3:0)
`define AFTME_REG_IN 4'h0
`define AFTME_REG_OUT 4'h1
`define AFTME_REG_STEP 4'h2
`define AFTME_REG_CNT 4'h3
`define AFTME_REG_CSR 4'h4
`define AFTME_REG_TBASE 4'h6
`define AFTME_REG_CBASE 4'h7
// ==========================================
// Control/status bit positions and reset value
`define AFTME_CSR_EN 0
`define AFTME_CSR_ADP 1
`define AFTME_CSR_IIR 2
`define AFTME_CSR_INIT 3
`define AFTME_CSR_BUSY 4
`define AFTME_CSR_OBF 5
`define AFTME_CSR_IBE 6
`define AFTME_CSR_IE 11
`define AFTME_CSR_RST 16'h0000
`endif

// >>> verilog/aftme_pkg.sv
// Types shared by both ends of the filter engine
`default_nettype none
package aftme_pkg;
  // ==========================================
  // Engine sequencer states
  typedef enum logic [2:0] {S_IDLE, S_INIT, S_FIR, S_OUT, S_WAITK, S_UPD} aftme_dev_state_t;
  // Host sequencer states
  typedef enum logic [1:0] {H_IDLE, H_CLR, H_CFG, H_RUN} aftme_host_state_t;
endpackage
`default_nettype wire

// >>> verilog/aftme_if.sv
// Peripheral bus between host end and filter engine
`timescale 1ns/10ps
`default_nettype none
`include "aftme_defines.svh"
interface aftme_if;
  // ==========================================
  // Host to engine
  logic wr;
  logic rd;
  logic [`AFTME_BUS_AW-1:0] addr;
  logic [`AFTME_DW-1:0] wdata;
  // Engine to host
  logic [`AFTME_DW-1:0] rdata;
  logic in_ready;
  logic irq;
  modport dev (input wr, input rd, input addr, input wdata,
               output rdata, output in_ready, output irq);
  modport host (output wr, output rd, output addr, output wdata,
                input rdata, input in_ready, input irq);
endinterface
`default_nettype wire

// >>> verilog/aftme_dev.sv
// Filter engine with shared tap/coefficient memories and input FIFO
// Overview of operation
// (R1) Coefficients read from Y memory at base
// (R2) Tap ring lives in X memory at base
// (R3) Coefficients stored highest index first
// (R4) No tap clearing unless initialization enabled
// (R5) IIR mode never touches tap buffer; the engine still writes samples into it and the host zeroes it first
// (R6) Tap ring length equals coefficient count
// (R7) One output per sample, sum coef times tap
// (R8) Adaptive: coef plus step times tap
// (R9) Host decides step size and error
// (R10) Update session starts on step write
// (R11) Output sets full flag, gated interrupt
// (R12) Host writes length minus one first
// (R13) Host feeds length minus one fill samples
// (R14) Update uses same taps, sample waits
// (R15) No sample accepted while session active; the input FIFO still takes up to 4, the engine pops only in S_IDLE
`timescale 1ns/10ps
`default_nettype none
`include "aftme_defines.svh"
// ==========================================
// Sample FIFO
module aftme_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_q [D]; // Storage words
  logic [PW-1:0] wp_q; // Write index
  logic [PW-1:0] rp_q; // Read index
  logic [CW-1:0] cnt_q; // Fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_q != CW'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Data store
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end
  // Pointers and level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == PW'(D - 1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == PW'(D - 1)) ? '0 : rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule
// ==========================================
// Engine
module aftme_dev (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Peripheral bus
  aftme_if.dev bus,
  // User side status
  output logic engine_busy
);
  localparam int DW = `AFTME_DW;
  localparam int AW = `AFTME_AW;
  logic [DW-1:0] xmem_q [`AFTME_MEM_WORDS]; // Tap memory
  logic [DW-1:0] ymem_q [`AFTME_MEM_WORDS]; // Coefficient memory
  aftme_pkg::aftme_dev_state_t st_q; // Sequencer state
  logic [15:0] csr_q; // Control bits
  logic [AW-1:0] cnt_q; // Length minus one
  logic [AW-1:0] tbase_q; // Tap ring base
  logic [AW-1:0] cbase_q; // Coefficient base
  logic [DW-1:0] step_q; // Update step
  logic [DW-1:0] out_q; // Filter output
  logic obf_q; // Output full flag
  logic en_prev_q; // Enable last cycle
  logic [AW-1:0] k_q; // Coefficient walk
  logic [AW-1:0] j_q; // Tap walk
  logic [AW-1:0] p_q; // Newest tap slot
  logic [AW-1:0] fill_q; // Fill samples taken
  logic [`AFTME_ACCW-1:0] acc_q; // Accumulator
  logic [DW-1:0] rdata_q; // Read data
  logic [1:0] space;
  logic [3:0] off;
  logic reg_wr;
  logic reg_rd;
  logic smp_valid;
  logic smp_pop;
  logic [DW-1:0] smp_data;
  logic [AW-1:0] p_nxt;
  logic [DW-1:0] coef;
  logic [DW-1:0] tap;
  logic signed [`AFTME_PRODW-1:0] prod;
  logic signed [`AFTME_PRODW-1:0] upd;
  logic out_rd;
  logic step_wr;
  // Ring increment wrapping at length minus one
  function automatic logic [AW-1:0] ring_inc(input logic [AW-1:0] v, input logic [AW-1:0] lim);
    ring_inc = (v == lim) ? '0 : v + 1'b1;
  endfunction
  // ==========================================
  // Bus decode
  assign space = bus.addr[13:12];
  assign off = bus.addr[3:0];
  assign reg_wr = bus.wr && (space == `AFTME_SPACE_REG);
  assign reg_rd = bus.rd && (space == `AFTME_SPACE_REG);
  assign out_rd = reg_rd && (off == `AFTME_REG_OUT);
  assign step_wr = reg_wr && (off == `AFTME_REG_STEP);
  // Sample FIFO in the data path
  aftme_fifo #(.W(DW), .D(`AFTME_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(reg_wr && (off == `AFTME_REG_IN) && csr_q[`AFTME_CSR_EN]),
    .in_ready(bus.in_ready),
    .in_data(bus.wdata),
    .out_valid(smp_valid),
    .out_ready(smp_pop),
    .out_data(smp_data)
  );
  // Pop only when idle and enabled
  assign smp_pop = (st_q == aftme_pkg::S_IDLE) && csr_q[`AFTME_CSR_EN] && en_prev_q; // R15
  assign p_nxt = ring_inc(p_q, cnt_q); // R6
  assign coef = ymem_q[cbase_q + k_q]; // R1
  assign tap = xmem_q[tbase_q + j_q]; // R2
  assign prod = $signed(coef) * $signed(tap);
  assign upd = $signed(step_q) * $signed(tap);
  assign bus.irq = obf_q && csr_q[`AFTME_CSR_IE]; // R11
  assign bus.rdata = rdata_q;
  assign engine_busy = (st_q != aftme_pkg::S_IDLE);
  // ==========================================
  // Configuration registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      csr_q <= `AFTME_CSR_RST;
      cnt_q <= '0;
      tbase_q <= '0;
      cbase_q <= '0;
      step_q <= '0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      en_prev_q <= csr_q[`AFTME_CSR_EN];
      if (reg_wr)
      begin
        case (off)
          `AFTME_REG_CSR: csr_q <= bus.wdata;
          `AFTME_REG_CNT: cnt_q <= bus.wdata[AW-1:0];
          `AFTME_REG_TBASE: tbase_q <= bus.wdata[AW-1:0];
          `AFTME_REG_CBASE: cbase_q <= bus.wdata[AW-1:0];
          `AFTME_REG_STEP: step_q <= bus.wdata;
          default: ;
        endcase
      end
    end
  end
  // ==========================================
  // Sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= aftme_pkg::S_IDLE;
      k_q <= '0;
      j_q <= '0;
      p_q <= '0;
      fill_q <= '0;
      acc_q <= '0;
    end
    else if (!csr_q[`AFTME_CSR_EN])
    begin
      // Held in reset while disabled; first sample lands in slot 0
      st_q <= aftme_pkg::S_IDLE;
      p_q <= cnt_q;
      fill_q <= '0;
      k_q <= '0;
    end
    else if (!en_prev_q)
    begin
      // Enable edge: clear taps only if asked and not IIR
      if (csr_q[`AFTME_CSR_INIT] && !csr_q[`AFTME_CSR_IIR]) // R4 R5
        st_q <= aftme_pkg::S_INIT;
      k_q <= '0;
    end
    else
    begin
      case (st_q)
        aftme_pkg::S_IDLE:
        begin
          if (smp_valid)
          begin
            p_q <= p_nxt;
            if (fill_q < cnt_q)
              fill_q <= fill_q + 1'b1;
            else
            begin
              // Oldest tap pairs with base coefficient (highest index)
              st_q <= aftme_pkg::S_FIR; // R7
              k_q <= '0;
              j_q <= ring_inc(p_nxt, cnt_q); // R3
              acc_q <= '0;
            end
          end
        end
        aftme_pkg::S_INIT:
        begin
          k_q <= k_q + 1'b1;
          if (k_q == cnt_q)
            st_q <= aftme_pkg::S_IDLE;
        end
        aftme_pkg::S_FIR:
        begin
          acc_q <= acc_q + {{(`AFTME_ACCW-`AFTME_PRODW){prod[`AFTME_PRODW-1]}}, prod}; // R7
          k_q <= k_q + 1'b1;
          j_q <= ring_inc(j_q, cnt_q); // R3
          if (k_q == cnt_q)
            st_q <= aftme_pkg::S_OUT;
        end
        aftme_pkg::S_OUT:
        begin
          // Adaptive mode parks until a step arrives
          st_q <= csr_q[`AFTME_CSR_ADP] ? aftme_pkg::S_WAITK : aftme_pkg::S_IDLE; // R8
        end
        aftme_pkg::S_WAITK:
        begin
          if (step_wr) // R10
          begin
            st_q <= aftme_pkg::S_UPD;
            k_q <= '0;
            j_q <= ring_inc(p_q, cnt_q); // R14
          end
        end
        aftme_pkg::S_UPD:
        begin
          k_q <= k_q + 1'b1;
          j_q <= ring_inc(j_q, cnt_q);
          if (k_q == cnt_q)
            st_q <= aftme_pkg::S_IDLE; // R14
        end
        default: st_q <= aftme_pkg::S_IDLE;
      endcase
    end
  end
  // ==========================================
  // Tap memory: engine writes win over host writes
  always_ff @(posedge clk)
  begin
    if (csr_q[`AFTME_CSR_EN] && en_prev_q && (st_q == aftme_pkg::S_IDLE) && smp_valid)
      xmem_q[tbase_q + p_nxt] <= smp_data; // R2
    else if (csr_q[`AFTME_CSR_EN] && en_prev_q && (st_q == aftme_pkg::S_INIT))
      xmem_q[tbase_q + k_q] <= '0; // R4
    else if (bus.wr && (space == `AFTME_SPACE_X))
      xmem_q[bus.addr[AW-1:0]] <= bus.wdata;
  end
  // Coefficient memory: update session writes back in place
  always_ff @(posedge clk)
  begin
    if (csr_q[`AFTME_CSR_EN] && en_prev_q && (st_q == aftme_pkg::S_UPD))
      ymem_q[cbase_q + k_q] <= coef + upd[`AFTME_FRAC+DW-1:`AFTME_FRAC]; // R8
    else if (bus.wr && (space == `AFTME_SPACE_Y))
      ymem_q[bus.addr[AW-1:0]] <= bus.wdata;
  end
  // ==========================================
  // Output register and full flag; set wins over read clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_q <= '0;
      obf_q <= 1'b0;
    end
    else if (st_q == aftme_pkg::S_OUT && csr_q[`AFTME_CSR_EN] && en_prev_q)
    begin
      out_q <= acc_q[`AFTME_FRAC+DW-1:`AFTME_FRAC]; // R7
      obf_q <= 1'b1; // R11
    end
    else if (out_rd)
      obf_q <= 1'b0;
  end
  // ==========================================
  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (bus.rd)
    begin
      case (space)
        `AFTME_SPACE_X: rdata_q <= xmem_q[bus.addr[AW-1:0]];
        `AFTME_SPACE_Y: rdata_q <= ymem_q[bus.addr[AW-1:0]];
        `AFTME_SPACE_REG:
        begin
          case (off)
            `AFTME_REG_OUT: rdata_q <= out_q;
            `AFTME_REG_STEP: rdata_q <= step_q;
            `AFTME_REG_CNT: rdata_q <= {4'h0, cnt_q};
            `AFTME_REG_TBASE: rdata_q <= {4'h0, tbase_q};
            `AFTME_REG_CBASE: rdata_q <= {4'h0, cbase_q};
            `AFTME_REG_CSR:
            begin
              rdata_q <= csr_q & 16'h080F;
              rdata_q[`AFTME_CSR_BUSY] <= engine_busy;
              rdata_q[`AFTME_CSR_OBF] <= obf_q;
              rdata_q[`AFTME_CSR_IBE] <= !smp_valid && !engine_busy; // R15
            end
            default: rdata_q <= '0;
          endcase
        end
        default: rdata_q <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verilog/aftme_host.sv
// Host end: tap preset, configuration, sample feed, output and step
`timescale 1ns/10ps
`default_nettype none
`include "aftme_defines.svh"
module aftme_host (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Peripheral bus
  aftme_if.host bus,
  // Memory preload (idle only)
  input wire logic mem_wr,
  input wire logic mem_y,
  input wire logic [`AFTME_AW-1:0] mem_addr,
  input wire logic [`AFTME_DW-1:0] mem_data,
  // Session control
  input wire logic start,
  input wire logic stop,
  input wire logic [`AFTME_AW-1:0] filt_len,
  input wire logic [`AFTME_AW-1:0] tap_base,
  input wire logic [`AFTME_AW-1:0] coef_base,
  input wire logic [`AFTME_DW-1:0] ctl,
  output logic idle,
  // Sample stream in
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [`AFTME_DW-1:0] smp_data,
  // Filter outputs
  output logic out_valid,
  output logic [`AFTME_DW-1:0] out_data,
  // Step from user
  input wire logic step_valid,
  output logic step_ready,
  input wire logic [`AFTME_DW-1:0] step_data
);
  aftme_pkg::aftme_host_state_t st_q; // Sequencer state
  logic [`AFTME_AW-1:0] n_q; // Walk index
  logic rd_pend_q; // Output read in flight
  logic [`AFTME_DW-1:0] out_q; // Captured output
  logic out_v_q; // Output pulse
  logic rd_go;
  logic stop_go;
  assign idle = (st_q == aftme_pkg::H_IDLE);
  assign rd_go = (st_q == aftme_pkg::H_RUN) && bus.irq && !rd_pend_q;
  assign step_ready = (st_q == aftme_pkg::H_RUN) && !rd_go; // R9
  assign smp_ready = step_ready && !step_valid && bus.in_ready; // R13
  assign stop_go = step_ready && !step_valid && !smp_valid && stop;
  assign out_valid = out_v_q;
  assign out_data = out_q;
  // ==========================================
  // Bus drive from state
  always_comb
  begin
    bus.wr = 1'b0;
    bus.rd = 1'b0;
    bus.addr = '0;
    bus.wdata = '0;
    case (st_q)
      aftme_pkg::H_IDLE:
      begin
        bus.wr = mem_wr;
        bus.addr = {mem_y ? `AFTME_SPACE_Y : `AFTME_SPACE_X, mem_addr};
        bus.wdata = mem_data;
      end
      aftme_pkg::H_CLR:
      begin
        // Zero history before enable
        bus.wr = 1'b1; // R4 R5
        bus.addr = {`AFTME_SPACE_X, tap_base + n_q};
      end
      aftme_pkg::H_CFG:
      begin
        bus.wr = 1'b1;
        case (n_q[1:0])
          2'h0: {bus.addr, bus.wdata} = {10'h200, `AFTME_REG_CNT, 4'h0, filt_len - 1'b1}; // R12
          2'h1: {bus.addr, bus.wdata} = {10'h200, `AFTME_REG_TBASE, 4'h0, tap_base};
          2'h2: {bus.addr, bus.wdata} = {10'h200, `AFTME_REG_CBASE, 4'h0, coef_base};
          default: {bus.addr, bus.wdata} = {10'h200, `AFTME_REG_CSR, ctl | 16'h0001};
        endcase
      end
      aftme_pkg::H_RUN:
      begin
        if (rd_go)
        begin
          bus.rd = 1'b1;
          bus.addr = {10'h200, `AFTME_REG_OUT};
        end
        else if (step_valid)
        begin
          bus.wr = 1'b1;
          bus.addr = {10'h200, `AFTME_REG_STEP};
          bus.wdata = step_data;
        end
        else if (smp_valid || stop)
        begin
          bus.wr = smp_valid ? bus.in_ready : 1'b1;
          bus.addr = {10'h200, smp_valid ? `AFTME_REG_IN : `AFTME_REG_CSR};
          bus.wdata = smp_valid ? smp_data : `AFTME_CSR_RST;
        end
      end
      default: ;
    endcase
  end
  // ==========================================
  // Sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= aftme_pkg::H_IDLE;
      n_q <= '0;
    end
    else
    begin
      case (st_q)
        aftme_pkg::H_IDLE:
        begin
          n_q <= '0;
          if (start && !mem_wr)
            st_q <= (!ctl[`AFTME_CSR_INIT] || ctl[`AFTME_CSR_IIR]) ? aftme_pkg::H_CLR
                                                                   : aftme_pkg::H_CFG;
        end
        aftme_pkg::H_CLR:
        begin
          n_q <= n_q + 1'b1;
          if (n_q == filt_len - 1'b1)
          begin
            st_q <= aftme_pkg::H_CFG;
            n_q <= '0;
          end
        end
        aftme_pkg::H_CFG:
        begin
          n_q <= n_q + 1'b1;
          if (n_q[1:0] == 2'h3)
            st_q <= aftme_pkg::H_RUN;
        end
        aftme_pkg::H_RUN:
        begin
          if (stop_go)
            st_q <= aftme_pkg::H_IDLE;
        end
        default: st_q <= aftme_pkg::H_IDLE;
      endcase
    end
  end
  // ==========================================
  // Output capture one cycle after the read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_pend_q <= 1'b0;
      out_v_q <= 1'b0;
      out_q <= '0;
    end
    else
    begin
      rd_pend_q <= rd_go;
      out_v_q <= rd_pend_q;
      if (rd_pend_q)
        out_q <= bus.rdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/aftme_sva.sv
// Bus checker for the filter engine, beside the host/engine interface
`timescale 1ns/10ps
`default_nettype none
`include "aftme_defines.svh"
module aftme_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus signals
  input wire logic wr,
  input wire logic rd,
  input wire logic [`AFTME_BUS_AW-1:0] addr,
  input wire logic [`AFTME_DW-1:0] wdata,
  input wire logic [`AFTME_DW-1:0] rdata,
  input wire logic in_ready,
  input wire logic irq
);
  // ==========================================
  // Decode of register accesses
  logic is_reg;
  logic wr_csr, wr_in, wr_step, wr_cnt, rd_out;
  assign is_reg = addr[13:12] == `AFTME_SPACE_REG;
  assign wr_csr = wr && is_reg && addr[3:0] == `AFTME_REG_CSR;
  assign wr_in = wr && is_reg && addr[3:0] == `AFTME_REG_IN;
  assign wr_step = wr && is_reg && addr[3:0] == `AFTME_REG_STEP;
  assign wr_cnt = wr && is_reg && addr[3:0] == `AFTME_REG_CNT;
  assign rd_out = rd && is_reg && addr[3:0] == `AFTME_REG_OUT;
  // ==========================================
  // Shadow state
  logic ie_q, adp_q, en_q, need_step_q;
  logic [11:0] cnt_q;
  logic [15:0] npush_q, nout_q;
  // Control word shadow
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) {ie_q, adp_q, en_q} <= 3'h0;
    else if (wr_csr) {ie_q, adp_q, en_q} <= {wdata[11], wdata[1], wdata[0]};
  // Length shadow
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) cnt_q <= 12'h000;
    else if (wr_cnt) cnt_q <= wdata[11:0];
  // Accepted samples and outputs since enable
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) {npush_q, nout_q} <= 32'h0;
    else if (wr_csr) {npush_q, nout_q} <= 32'h0;
    else
    begin
      if (wr_in && in_ready && en_q) npush_q <= npush_q + 16'h1;
      if ($rose(irq)) nout_q <= nout_q + 16'h1;
    end
  // Adaptive output still waiting for its step
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) need_step_q <= 1'b0;
    else if (wr_csr || wr_step) need_step_q <= 1'b0;
    else if ($rose(irq) && adp_q) need_step_q <= 1'b1;
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_irq_mask_off: assert property (wr_csr && !wdata[`AFTME_CSR_IE] |=> !irq)
    else $error("irq high after enable bit cleared");
  a_irq_gate: assert property (irq |-> ie_q)
    else $error("irq high while its enable is off");
  a_irq_read_clears: assert property (rd_out && irq |=> !irq)
    else $error("output read did not clear full flag");
  a_irq_holds: assert property (irq && !rd_out && !wr_csr |=> irq)
    else $error("full flag dropped without a read");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_fill_first: assert property (irq |-> npush_q > cnt_q)
    else $error("output before delay line filled");
  a_one_per_sample: assert property ($rose(irq) |-> nout_q + cnt_q < npush_q)
    else $error("more outputs than samples");
  a_step_waits: assert property ($rose(irq) |-> !need_step_q)
    else $error("new output before step written");
endmodule
`default_nettype wire

// >>> tb/aftme_tb_top.sv
// Testbench joining host end and filter engine, with output model
`timescale 1ns/10ps
`default_nettype none
`include "aftme_defines.svh"
module aftme_tb_top;
  // ==========================================
  // Signals
  logic clk, nrst, mem_wr, mem_y, start, stop, idle, engine_busy, full_seen;
  logic smp_valid, smp_ready, out_valid, step_valid, step_ready, adp, step_tk;
  logic [11:0] mem_addr, filt_len, tap_base, coef_base;
  logic [15:0] mem_data, ctl, smp_data, out_data, step_data;
  logic [15:0] coef [8];
  logic [15:0] hist [8];
  logic [15:0] exp_q [$];
  logic [15:0] step_q [$];
  logic [15:0] xs [$];
  integer seed, fails, n_checks, nouts, nsteps;
  // ==========================================
  // Design and checker
  aftme_if i_aftme_if ();
  aftme_dev i_aftme_dev (.clk(clk), .nrst(nrst), .bus(i_aftme_if), .engine_busy(engine_busy));
  aftme_host i_aftme_host (.clk(clk), .nrst(nrst), .bus(i_aftme_if), .mem_wr(mem_wr),
    .mem_y(mem_y), .mem_addr(mem_addr), .mem_data(mem_data), .start(start), .stop(stop),
    .filt_len(filt_len), .tap_base(tap_base), .coef_base(coef_base), .ctl(ctl), .idle(idle),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .out_valid(out_valid), .out_data(out_data), .step_valid(step_valid),
    .step_ready(step_ready), .step_data(step_data));
  aftme_sva i_aftme_sva (.clk(clk), .nrst(nrst), .wr(i_aftme_if.wr), .rd(i_aftme_if.rd),
    .addr(i_aftme_if.addr), .wdata(i_aftme_if.wdata), .rdata(i_aftme_if.rdata),
    .in_ready(i_aftme_if.in_ready), .irq(i_aftme_if.irq));
  // Clock at 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Common tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  // ==========================================
  // Filter model: sum of coef[i] times x(n-i), then step update
  function automatic logic [15:0] fir_out(input int n);
    logic signed [39:0] acc;
    acc = 40'h0;
    for (int i = 0; i < n; i++) acc = acc + $signed(coef[i]) * $signed(hist[i]);
    return acc[30:15];
  endfunction
  function automatic void coef_upd(input int n, input logic [15:0] k);
    logic signed [31:0] p;
    for (int i = 0; i < n; i++)
    begin
      p = $signed(k) * $signed(hist[i]);
      coef[i] = coef[i] + p[30:15];
    end
  endfunction
  // ==========================================
  // Output monitor, values sampled before the edge lands
  always @(posedge clk)
    if (out_valid === 1'b1)
    begin
      check(out_data, exp_q.pop_front());
      nouts++;
    end
  // Step feeder, held until taken, randomly late so samples pile up
  always @(posedge clk)
  begin
    // Taken only when both were high at this edge; never withdrawn before that
    step_tk = (step_valid === 1'b1 && step_ready === 1'b1);
    if (step_tk) nsteps++;
    if (i_aftme_if.in_ready === 1'b0) full_seen = 1'b1;
    #1;
    if (step_valid !== 1'b1 || step_tk)
    begin
      step_valid <= adp && (nsteps < nouts) && (($random(seed) & 31) == 0);
      step_data <= step_q[nsteps];
    end
  end
  // Sample push after a random gap
  task send(input logic [15:0] d);
    integer w;
    w = 0;
    repeat (($random(seed) & 3) + 1) tick;
    smp_valid = 1'b1;
    smp_data = d;
    @(posedge clk);
    while (smp_ready !== 1'b1 && w < 3000)
    begin
      w++;
      @(posedge clk);
    end
    #1;
    smp_valid = 1'b0;
  endtask
  // One filter run: preload, start, feed, drain, stop
  task run(input logic [15:0] mode, input int n, input int m);
    integer w;
    adp = mode[`AFTME_CSR_ADP];
    tap_base = 12'($random(seed)) & 12'hFF0;
    coef_base = 12'($random(seed)) & 12'hFF0;
    for (int i = 0; i < n; i++)
    begin
      coef[i] = 16'($random(seed));
      hist[i] = 16'h0000;
      mem_wr = 1'b1;
      mem_y = 1'b1;
      mem_addr = 12'(coef_base + n - 1 - i);
      mem_data = coef[i];
      tick;
    end
    mem_wr = 1'b0;
    for (int k = 0; k < n - 1 + m; k++)
    begin
      for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = 16'($random(seed));
      xs.push_back(hist[0]);
      if (k >= n - 1) exp_q.push_back(fir_out(n));
      if (k >= n - 1 && adp) step_q.push_back(16'($random(seed)));
      if (k >= n - 1 && adp) coef_upd(n, step_q[step_q.size()-1]);
    end
    nouts = 0;
    nsteps = 0;
    filt_len = 12'(n);
    ctl = mode | 16'h0800;
    start = 1'b1;
    w = 0;
    tick;
    while (idle !== 1'b0 && w < 100) begin w++; tick; end
    start = 1'b0;
    while (xs.size() > 0) send(xs.pop_front());
    w = 0;
    while ((nouts < m || (adp && nsteps < m)) && w < 8000) begin w++; tick; end
    repeat (2 * n + 8) tick;
    check(16'(nouts), 16'(m));
    check({15'h0, engine_busy}, 16'h0000);
    stop = 1'b1;
    w = 0;
    while (idle !== 1'b1 && w < 100) begin w++; tick; end
    stop = 1'b0;
    step_q.delete();
    exp_q.delete();
  endtask
  // ==========================================
  // Main sequence over modes and lengths
  initial
  begin
    seed = 32'h7c614c61;
    {fails, n_checks, nouts, nsteps} = 0;
    {nrst, mem_wr, mem_y, start, stop, smp_valid, step_valid, adp, full_seen} = 9'h0;
    {mem_addr, filt_len, tap_base, coef_base} = 48'h0;
    {mem_data, ctl, smp_data, step_data} = 64'h0;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    tick;
    run(16'h0000, 1, 4);
    run(16'h0008, 5, 6);
    run(16'h000C, 4, 5);
    run(16'h0002, 6, 8);
    run(16'h000A, 3, 6);
    check({15'h0, full_seen}, 16'h0001);
    finish_test;
  end
  // Watchdog for a hung handshake
  initial
  begin
    #(100 * 60000);
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
